// ---- rtl/ind_acc_pkg.sv ----
// Purpose: Constants for the indirect access and self-test register slice
// Assumes: 32-bit APB, printed offsets are indices (not all multiples of four)
// Notes:   Byte address of a register is four times its index
`default_nettype none
package ind_acc_pkg;
  // ==========================================================
  // Register indices and byte addresses
  localparam logic [7:0]  IDX_REF_RATE = 8'ha5;
  localparam logic [7:0]  IDX_IND_CTL  = 8'hb0;
  localparam logic [7:0]  IDX_IND_OFS  = 8'hb1;
  localparam logic [7:0]  IDX_IND_VAL  = 8'hb2;
  localparam logic [7:0]  IDX_ST_CTL   = 8'hb3;
  localparam logic [11:0] ADDR_REF_RATE = {2'h0, IDX_REF_RATE, 2'h0};
  localparam logic [11:0] ADDR_IND_CTL  = {2'h0, IDX_IND_CTL, 2'h0};
  localparam logic [11:0] ADDR_IND_OFS  = {2'h0, IDX_IND_OFS, 2'h0};
  localparam logic [11:0] ADDR_IND_VAL  = {2'h0, IDX_IND_VAL, 2'h0};
  localparam logic [11:0] ADDR_ST_CTL   = {2'h0, IDX_ST_CTL, 2'h0};
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_IND_CTL = 8'h1c;
  localparam logic [7:0] RST_IND_OFS = 8'h3a;
  localparam logic [7:0] RST_IND_VAL = 8'h14;
  localparam logic [7:0] RST_ST_CTL  = 8'h08;
  // ==========================================================
  // Field positions
  localparam int CTL_PREFETCH_BIT = 0;
  localparam int CTL_STEP_BIT     = 1;
  localparam int CTL_SEL_LO       = 2;
  localparam int CTL_SEL_HI       = 5;
  localparam int ST_EN_BIT        = 0;
  localparam int ST_CLK_LO        = 1;
  localparam int ST_CLK_HI        = 2;
  localparam int ST_CFG_BIT       = 3;
  localparam int ST_MODE_LO       = 6;
  localparam int ST_MODE_HI       = 7;
  localparam logic [3:0] SEL_PATTERN_TIMING = 4'h0;
  // Serializer register that takes the self-test clock choice
  localparam logic [7:0] SER_CLK_SRC_OFS = 8'h14;
  localparam logic [1:0] PAT_NONE = 2'h0;
  localparam logic [1:0] PAT_ALT  = 2'h1;
endpackage : ind_acc_pkg
`default_nettype wire

// ---- rtl/ind_acc_regs.sv ----
// Purpose: APB register slice: clock rate reading, indirect port, self-test control
// Assumes: Secondary block answers a read strobe with data in the next cycle
// Notes:   No wait state on any APB access; pready is high in the first access cycle
//
// Contract
// - Reference clock MHz shown read-only
// - Select field picks target; nonzero reserved
// - Step enable advances offset after access
// - Prefetch: offset write issues read strobe
// - Prefetch plus step: value read refetches
// - Offset register 8 bit, reset 0x3a
// - Value write does indirect write
// - Value read returns target register
// - Value reset nominal 0x14, not relied
// - Pattern field 00 none 01 alt 1x data
// - Clock choice field in bits 2:1
// - Enable rising pushes clock choice to serializer
// - Bit 3 reads zero
//
// Implementation choice: the APB slave port.
`default_nettype none
module ind_acc_regs
  import ind_acc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  ref_rate_mhz,
  output logic             tgt_wr,
  output logic             tgt_rd,
  output logic [3:0]       tgt_sel,
  output logic [7:0]       tgt_ofs,
  output logic [7:0]       tgt_wdata,
  input  wire logic [7:0]  tgt_rdata,
  output logic             ser_wr,
  output logic [7:0]       ser_ofs,
  output logic [1:0]       ser_wdata,
  input  wire logic        st_data,
  output logic             st_out
);
  // ==========================================================
  // Bus decode
  logic [7:0] ctl_ff;
  logic [7:0] ofs_ff;
  logic [7:0] val_ff;
  logic [7:0] st_ff;
  logic       rd_pend_ff;
  logic       st_out_ff;
  logic       pready_ff;

  wire        setup     = psel & ~penable;
  wire        access    = psel & penable & pready_ff;
  wire        wr_acc    = access & pwrite;
  wire        rd_acc    = access & ~pwrite;
  wire        lane0     = pstrb[0];
  wire        hit_rate  = (paddr == ADDR_REF_RATE);
  wire        hit_ctl   = (paddr == ADDR_IND_CTL);
  wire        hit_ofs   = (paddr == ADDR_IND_OFS);
  wire        hit_val   = (paddr == ADDR_IND_VAL);
  wire        hit_st    = (paddr == ADDR_ST_CTL);
  wire        hit_any   = hit_rate | hit_ctl | hit_ofs | hit_val | hit_st;
  wire        prefetch  = ctl_ff[CTL_PREFETCH_BIT];
  wire        step      = ctl_ff[CTL_STEP_BIT];
  wire [3:0]  sel       = ctl_ff[CTL_SEL_HI:CTL_SEL_LO];
  // Reserved targets get no strobes at all
  wire        sel_ok    = (sel == SEL_PATTERN_TIMING);
  wire        wr_ctl    = wr_acc & hit_ctl & lane0;
  wire        wr_ofs    = wr_acc & hit_ofs & lane0;
  wire        wr_val    = wr_acc & hit_val & lane0;
  wire        wr_st     = wr_acc & hit_st & lane0;
  wire        rd_val    = rd_acc & hit_val;
  wire        val_acc   = wr_val | rd_val;

  // ==========================================================
  // Read mux
  wire [7:0] st_view = {st_ff[ST_MODE_HI:ST_MODE_LO], 2'h0, 1'b0,
                        st_ff[ST_CLK_HI:ST_CLK_LO], st_ff[ST_EN_BIT]};
  logic [7:0] rd_byte;
  always_comb begin
    if (hit_rate) begin
      rd_byte = ref_rate_mhz;
    end else if (hit_ctl) begin
      rd_byte = {2'h0, ctl_ff[5:0]};
    end else if (hit_ofs) begin
      rd_byte = ofs_ff;
    end else if (hit_val) begin
      rd_byte = val_ff;
    end else if (hit_st) begin
      rd_byte = st_view;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // ==========================================================
  // Indirect strobes and offset
  wire [7:0] ofs_inc    = ofs_ff + 8'h01;
  wire       do_step    = step & val_acc;
  wire [7:0] nxt_ofs    = wr_ofs ? pwdata[7:0] : (do_step ? ofs_inc : ofs_ff);
  // Prefetch after a value read only in step mode, at the advanced offset
  wire       nxt_rd     = sel_ok & prefetch & (wr_ofs | (rd_val & step));
  wire       nxt_wr     = sel_ok & wr_val;
  wire       st_rise    = wr_st & pwdata[ST_EN_BIT] & ~st_ff[ST_EN_BIT];
  wire [7:0] nxt_st     = wr_st ? {pwdata[7:6], 2'h0, 1'b0, pwdata[2:0]} : st_ff;

  // Pattern output; alternating mode divides the block clock by two
  wire [1:0] pat        = st_ff[ST_MODE_HI:ST_MODE_LO];
  wire       nxt_st_out = ~st_ff[ST_EN_BIT] ? 1'b0 :
                          (pat == PAT_NONE) ? 1'b0 :
                          (pat == PAT_ALT)  ? ~st_out_ff : st_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff       <= RST_IND_CTL;
      ofs_ff       <= RST_IND_OFS;
      val_ff       <= RST_IND_VAL;
      st_ff        <= RST_ST_CTL & 8'hf7;
      rd_pend_ff   <= 1'b0;
      st_out_ff    <= 1'b0;
      pready_ff    <= 1'b0;
      prdata       <= 32'h0000_0000;
      pslverr      <= 1'b0;
      tgt_wr       <= 1'b0;
      tgt_rd       <= 1'b0;
      tgt_wdata    <= 8'h00;
      ser_wr       <= 1'b0;
      ser_wdata    <= 2'h0;
    end else if (clk_en) begin
      pready_ff    <= setup;
      pslverr      <= setup & ~hit_any;
      prdata       <= (setup & ~pwrite) ? {24'h0, rd_byte} : 32'h0000_0000;
      if (wr_ctl) begin
        ctl_ff <= {2'h0, pwdata[5:0]};
      end
      ofs_ff       <= nxt_ofs;
      st_ff        <= nxt_st;
      tgt_wr       <= nxt_wr;
      tgt_rd       <= nxt_rd;
      rd_pend_ff   <= tgt_rd;
      if (wr_val) begin
        val_ff    <= pwdata[7:0];
        tgt_wdata <= pwdata[7:0];
      end else if (rd_pend_ff) begin
        val_ff <= tgt_rdata;
      end
      ser_wr       <= st_rise;
      if (st_rise) begin
        ser_wdata <= pwdata[ST_CLK_HI:ST_CLK_LO];
      end
      st_out_ff    <= nxt_st_out;
    end
  end

  assign pready   = pready_ff;
  assign tgt_sel  = ctl_ff[CTL_SEL_HI:CTL_SEL_LO];
  assign tgt_ofs  = ofs_ff;
  assign ser_ofs  = SER_CLK_SRC_OFS;
  assign st_out   = st_out_ff;
endmodule : ind_acc_regs
`default_nettype wire

// ---- tb/ind_acc_regs_assertions.sv ----
// Purpose: Port-level checks for the register slice
// Assumes: One access cycle per APB transfer
// Notes:   Attached to every instance by bind
`default_nettype none
module ind_acc_regs_checker
  import ind_acc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic [7:0]  ref_rate_mhz,
  input wire logic        tgt_wr,
  input wire logic [3:0]  tgt_sel,
  input wire logic        ser_wr,
  input wire logic [7:0]  ser_ofs,
  input wire logic [1:0]  ser_wdata
);
  // =====
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence rd_s(logic [11:0] a); setup_s ##0 (!pwrite && paddr == a); endsequence
  a_ready_follows: assert property (setup_s |=> pready) else $error("no pready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_rate_shown: assert property (rd_s(ADDR_REF_RATE) |=> prdata[7:0] == ref_rate_mhz)
    else $error("rate read wrong");
  a_cfg_bit_zero: assert property (rd_s(ADDR_ST_CTL) |=> !prdata[3])
    else $error("config bit set");
  a_wr_target: assert property (tgt_wr |-> tgt_sel == SEL_PATTERN_TIMING)
    else $error("write to reserved target");
  a_wr_pulse: assert property (tgt_wr |=> !tgt_wr) else $error("write strobe held");
  a_ser_push: assert property (ser_wr |-> ser_ofs == SER_CLK_SRC_OFS &&
    $past(pready && pwrite && paddr == ADDR_ST_CTL)) else $error("bad serializer push");
  a_ser_data: assert property (ser_wr |-> ser_wdata == $past(pwdata[2:1]))
    else $error("bad clock choice");
endmodule : ind_acc_regs_checker
bind ind_acc_regs ind_acc_regs_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .ref_rate_mhz, .tgt_wr, .tgt_sel, .ser_wr, .ser_ofs,
  .ser_wdata);
`default_nettype wire

// ---- tb/ind_acc_regs_bench.sv ----
// Purpose: Self-checking bench for the register slice
// Assumes: clk_en and byte strobes held on
// Notes:   Each transfer queues its expected response
`default_nettype none
module ind_acc_regs_bench import ind_acc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        st_data = 1'b0, pready, pslverr, tgt_wr, tgt_rd, ser_wr, st_out, a;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0]  ref_rate_mhz, tgt_rdata, tgt_ofs, tgt_wdata, ser_ofs, w_ofs, w_dat, r_ofs, d;
  logic [3:0]  tgt_sel;
  logic [1:0]  ser_wdata;
  logic [32:0] q[$];
  int          n_fail = 0, samples_checked = 0, n_wr = 0, n_rd = 0, k, seed = 32'h6da177f5;
  // =====
  // Design and helpers
  ind_acc_regs ind_acc_regs_i (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hf), .pready, .prdata, .pslverr, .ref_rate_mhz, .tgt_wr, .tgt_rd,
    .tgt_sel, .tgt_ofs, .tgt_wdata, .tgt_rdata, .ser_wr, .ser_ofs, .ser_wdata, .st_data, .st_out);
  initial forever #2 pclk = ~pclk;
  task automatic check(string nm, logic [32:0] ex, logic [32:0] got);
    samples_checked++;
    if (got !== ex) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, ex, got);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic apb(logic w, logic [11:0] ad, logic [31:0] wd, logic [32:0] ex);
    q.push_back(ex);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, wd};
    @(posedge pclk) penable <= 1'b1;
    k = 0;
    do @(posedge pclk) k++; while (pready !== 1'b1 && k < 9);
    if (k >= 9) n_fail++;
    if (k >= 9) tally_and_finish();
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb
  task automatic wr(logic [11:0] ad, logic [31:0] x); apb(1'b1, ad, x, 33'h0); endtask : wr
  task automatic rd(logic [11:0] ad, logic [31:0] x); apb(1'b0, ad, 0, {1'b0, x}); endtask : rd
  // Mid-cycle sampling keeps the monitor clear of the driving edge
  always @(negedge pclk) begin
    if (pready === 1'b1 && q.size() > 0) check("resp", q.pop_front(), {pslverr, prdata});
    if (tgt_wr === 1'b1) {n_wr, w_ofs, w_dat} = {n_wr + 1, tgt_ofs, tgt_wdata};
    if (tgt_rd === 1'b1) {n_rd, r_ofs} = {n_rd + 1, tgt_ofs};
  end
  initial begin
    ref_rate_mhz <= 8'($random(seed));
    tgt_rdata <= 8'($random(seed));
    d <= 8'($random(seed));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_IND_CTL, 32'h1c);
    rd(ADDR_IND_OFS, 32'h3a);
    rd(ADDR_ST_CTL, 32'h00);
    rd(ADDR_REF_RATE, 32'(ref_rate_mhz));
    apb(1'b1, 12'h000, 32'h1, 33'h1_0000_0000);
    wr(ADDR_IND_VAL, 32'h55);
    check("reserved", 0, 33'(n_wr));
    $display("reset test done");
    wr(ADDR_IND_CTL, 32'h00);
    wr(ADDR_IND_OFS, 32'hff);
    wr(ADDR_IND_VAL, 32'(d));
    check("write", 33'({8'hff, d}), 33'({w_ofs, w_dat}));
    wr(ADDR_IND_CTL, 32'h02);
    wr(ADDR_IND_VAL, 32'h0);
    rd(ADDR_IND_OFS, 32'h00);
    $display("write test done");
    wr(ADDR_IND_CTL, 32'h03);
    wr(ADDR_IND_OFS, 32'h10);
    repeat (3) @(posedge pclk);
    rd(ADDR_IND_VAL, 32'(tgt_rdata));
    rd(ADDR_IND_OFS, 32'h11);
    check("fetch", 33'h211, 33'({n_rd[7:0], r_ofs}));
    $display("fetch test done");
    wr(ADDR_ST_CTL, 32'h0f);
    rd(ADDR_ST_CTL, 32'h07);
    wr(ADDR_ST_CTL, 32'h43);
    @(negedge pclk);
    a = st_out;
    @(negedge pclk);
    check("alternate", 33'(!a), 33'(st_out));
    st_data <= 1'b1;
    wr(ADDR_ST_CTL, 32'h81);
    @(negedge pclk);
    check("follow", 33'h1, 33'(st_out));
    wr(ADDR_ST_CTL, 32'h01);
    @(negedge pclk);
    check("quiet", 33'h0, 33'(st_out));
    $display("selftest test done");
    tally_and_finish();
  end
endmodule : ind_acc_regs_bench
`default_nettype wire
